// ### pkg/ipc_prio_regs.vh
// Purpose: Register map, field layout and reset values of the priority controller
// Assumes: 16-bit registers on a plain strobe port, word addresses
// Notes:   Included by the design, assertion and bench files
`ifndef IPC_PRIO_REGS_VH
`define IPC_PRIO_REGS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define IPC_ADDR_W 4
`define IPC_A_PRIO15 4'h0
`define IPC_A_PRIO16 4'h1
`define IPC_A_PRIO17 4'h2
`define IPC_A_STATUS 4'h3
`define IPC_A_CTRL1 4'h4
`define IPC_A_FLAGS 4'h5
`define IPC_A_ENABLE 4'h6
`define IPC_A_CPULVL 4'h7
`define IPC_A_DISCNT 4'h8
`define IPC_A_EVST 4'h9
`define IPC_A_EVMASK 4'hA

// ----------------------------------------
// Field layout
// ----------------------------------------
`define IPC_PRIO_W 3
`define IPC_LVL_W 4
`define IPC_VEC_W 7
`define IPC_NSRC 8
`define IPC_NTRAP 4
// Writable bits of the three priority registers
`define IPC_MASK15 16'h0077
`define IPC_MASK16 16'h0770
`define IPC_MASK17 16'h7777
`define IPC_NEST_BIT 15
`define IPC_LVL_LSB 8
// Source index to vector code offset
`define IPC_VEC_BASE 7'h40

// ----------------------------------------
// Reset values and levels
// ----------------------------------------
`define IPC_PRIO_RST 3'h4
`define IPC_RST15 16'h0044
`define IPC_RST16 16'h0440
`define IPC_RST17 16'h4444
`define IPC_LVL_USERMAX 4'h7
`define IPC_LVL_TRAP 4'h8
`define IPC_LVL_TIMED_IRQ_DISABLE_INSTR 3'h7
`define IPC_LVL_ZERO 4'h0
`define IPC_DISCNT_W 14

`endif

// ### hdl/ipc_prio_pick.v
// Purpose: Picks the highest-priority eligible user source
// Assumes: Levels already gated by enable, flag and masking
// Notes:   Ties go to the lower source index
`timescale 1ns/100ps
`default_nettype none
`include "ipc_prio_regs.vh"

module ipc_prio_pick #(
	parameter NSRC = `IPC_NSRC
) (
	// Per-source effective levels, zero when not eligible
	input wire [NSRC*`IPC_PRIO_W-1:0] srcLevel,
	// Winner
	output reg found,
	output reg [`IPC_PRIO_W-1:0] bestLevel,
	output reg [`IPC_VEC_W-1:0] bestIdx
);
	integer i;

	// ----------------------------------------
	// Strict greater-than keeps the lowest index on ties
	// ----------------------------------------
	always @* begin
		found = 1'b0;
		bestLevel = {`IPC_PRIO_W{1'b0}};
		bestIdx = {`IPC_VEC_W{1'b0}};
		for (i = 0; i < NSRC; i = i + 1) begin
			if (srcLevel[i*`IPC_PRIO_W +: `IPC_PRIO_W] > bestLevel) begin
				found = 1'b1;
				bestLevel = srcLevel[i*`IPC_PRIO_W +: `IPC_PRIO_W];
				bestIdx = i[`IPC_VEC_W-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/ipc_prio_ctrl.v
// Purpose: Interrupt priority arbitration with priority, status and control registers
// Assumes: One 20 MHz clock, plain strobe register port, CPU handshake by pulses
// Notes:   Eight user sources in three priority registers, four trap sources
//
// Operation
// - each source has a 3-bit priority, 7 highest down to 1
// - priority zero disables the source completely
// - all priority fields reset to level 4
// - unimplemented bits read zero and ignore writes
// - status bits 11-8 show the new CPU level, reset zero
// - status bits 6-0 show the vector code taken at the last acknowledge
// - nesting disable bit 15 of control one blocks preemption by user sources
// - a flag still set after return is requested again at once
// - return restores saved status low byte and old CPU level
// - trap is re-taken until its status flag is cleared
// - CPU level 7 masks all user sources, only levels up to 7 masked
// - traps are levels 8 to 11, masked only by a trap of equal or higher level in service
// - timed disable blocks levels 1 to 6, level 7 still serviced
// - a source requests only while its enable bit is set
// - priority register 15 holds DMA5 bits 6-4, codec bits 2-0
// - priority register 16 holds UART B bits 10-8, UART A bits 6-4
// - priority register 17 holds CAN B, CAN A, DMA7, DMA6 fields
`timescale 1ns/100ps
`default_nettype none
`include "ipc_prio_regs.vh"

module ipc_prio_ctrl #(
	parameter NSRC = `IPC_NSRC
) (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Register port
	input wire [`IPC_ADDR_W-1:0] regAddr,
	input wire [15:0] regWdata,
	input wire regWr,
	input wire regRd,
	output reg [15:0] regRdata,
	// Sources: flag set pulses and trap events
	input wire [NSRC-1:0] srcEvent,
	input wire [`IPC_NTRAP-1:0] trapEvent,
	// CPU handshake
	input wire cpuAck,
	input wire cpuReturn,
	input wire [7:0] cpuSavedSrl,
	input wire timedDisStart,
	input wire [`IPC_DISCNT_W-1:0] timedDisCycles,
	// Request to CPU
	output reg irqReq,
	output reg [`IPC_LVL_W-1:0] irqLevel,
	output reg [`IPC_VEC_W-1:0] irqVector,
	output reg [7:0] restoredSrl,
	output reg restoreValid,
	// Event interrupt
	output reg irqOut
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [15:0] prio15_q;
	reg [15:0] prio16_q;
	reg [15:0] prio17_q;
	reg nestDis_q;
	reg [`IPC_NTRAP-1:0] trapFlag_q;
	reg [NSRC-1:0] flag_q;
	reg [NSRC-1:0] enable_q;
	reg [`IPC_LVL_W-1:0] cpuLvl_q;
	reg [`IPC_LVL_W-1:0] newLvl_q;
	reg [`IPC_VEC_W-1:0] vecCode_q;
	reg [`IPC_DISCNT_W-1:0] disCnt_q;
	reg [`IPC_LVL_W-1:0] stackLvl_q [0:15];
	reg [7:0] stackSrl_q [0:15];
	reg [3:0] sp_q;
	reg inService_q;
	reg [1:0] evSt_q;
	reg [1:0] evMask_q;

	wire [NSRC*`IPC_PRIO_W-1:0] prioVec;
	wire [NSRC*`IPC_PRIO_W-1:0] effVec;
	wire found;
	wire [`IPC_PRIO_W-1:0] bestLevel;
	wire [`IPC_VEC_W-1:0] bestIdx;
	wire wrHit;

	// Field order: codec, DMA5, UART A, UART B, DMA6, DMA7, CAN A, CAN B
	assign prioVec = {prio17_q[14:12], prio17_q[10:8], prio17_q[6:4], prio17_q[2:0],
		prio16_q[10:8], prio16_q[6:4], prio15_q[6:4], prio15_q[2:0]};

	function wireLvlOk;
		input [`IPC_PRIO_W-1:0] lvl;
		input [`IPC_LVL_W-1:0] cpu;
		input disOn;
		begin
			// Zero never requests; CPU level 7 blocks every user level
			wireLvlOk = (lvl != {`IPC_PRIO_W{1'b0}}) && ({1'b0, lvl} > cpu)
				&& !(disOn && lvl != `IPC_LVL_TIMED_IRQ_DISABLE_INSTR);
		end
	endfunction

	// ----------------------------------------
	// Eligibility per source
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1) begin : gElig
			wire [`IPC_PRIO_W-1:0] lvl = prioVec[g*`IPC_PRIO_W +: `IPC_PRIO_W];
			wire ok = flag_q[g] && enable_q[g]
				&& wireLvlOk(lvl, cpuLvl_q, disCnt_q != {`IPC_DISCNT_W{1'b0}});
			assign effVec[g*`IPC_PRIO_W +: `IPC_PRIO_W] = ok ? lvl : {`IPC_PRIO_W{1'b0}};
		end
	endgenerate

	ipc_prio_pick #(
		.NSRC(NSRC)
	) uPick (
		.srcLevel(effVec),
		.found(found),
		.bestLevel(bestLevel),
		.bestIdx(bestIdx)
	);

	// ----------------------------------------
	// Trap and user arbitration
	// ----------------------------------------
	reg trapAny;
	reg [`IPC_LVL_W-1:0] trapLvl;
	reg [`IPC_VEC_W-1:0] trapVec;
	reg pendAny;
	reg [`IPC_LVL_W-1:0] pendLvl;
	reg [`IPC_VEC_W-1:0] pendVec;
	integer t;
	always @* begin
		trapAny = 1'b0;
		trapLvl = `IPC_LVL_ZERO;
		trapVec = {`IPC_VEC_W{1'b0}};
		// Traps ignore timed disable but must exceed CPU level; higher index wins
		for (t = 0; t < `IPC_NTRAP; t = t + 1) begin
			if (trapFlag_q[t]) begin
				trapAny = 1'b1;
				trapLvl = `IPC_LVL_TRAP + t[`IPC_LVL_W-1:0];
				trapVec = t[`IPC_VEC_W-1:0];
			end
		end
		if (trapAny && trapLvl > cpuLvl_q) begin
			pendAny = 1'b1;
			pendLvl = trapLvl;
			pendVec = trapVec;
		end else begin
			pendAny = found && !(nestDis_q && inService_q);
			pendLvl = {1'b0, bestLevel};
			pendVec = `IPC_VEC_BASE + bestIdx;
		end
	end

	assign wrHit = regWr;

	// ----------------------------------------
	// Register writes, flags and service tracking
	// ----------------------------------------
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prio15_q <= `IPC_RST15;
			prio16_q <= `IPC_RST16;
			prio17_q <= `IPC_RST17;
			nestDis_q <= 1'b0;
			trapFlag_q <= {`IPC_NTRAP{1'b0}};
			flag_q <= {NSRC{1'b0}};
			enable_q <= {NSRC{1'b0}};
			cpuLvl_q <= `IPC_LVL_ZERO;
			newLvl_q <= `IPC_LVL_ZERO;
			vecCode_q <= {`IPC_VEC_W{1'b0}};
			disCnt_q <= {`IPC_DISCNT_W{1'b0}};
			sp_q <= 4'h0;
			inService_q <= 1'b0;
			evSt_q <= 2'h0;
			evMask_q <= 2'h0;
			irqReq <= 1'b0;
			irqLevel <= `IPC_LVL_ZERO;
			irqVector <= {`IPC_VEC_W{1'b0}};
			restoredSrl <= 8'h00;
			restoreValid <= 1'b0;
			irqOut <= 1'b0;
		end else begin
			restoreValid <= 1'b0;
			if (wrHit && regAddr == `IPC_A_PRIO15) begin
				prio15_q <= regWdata & `IPC_MASK15;
			end else if (wrHit && regAddr == `IPC_A_PRIO16) begin
				prio16_q <= regWdata & `IPC_MASK16;
			end else if (wrHit && regAddr == `IPC_A_PRIO17) begin
				prio17_q <= regWdata & `IPC_MASK17;
			end else if (wrHit && regAddr == `IPC_A_CTRL1) begin
				nestDis_q <= regWdata[`IPC_NEST_BIT];
			end else if (wrHit && regAddr == `IPC_A_ENABLE) begin
				enable_q <= regWdata[NSRC-1:0];
			end else if (wrHit && regAddr == `IPC_A_CPULVL) begin
				// Software reaches user levels only; trap levels come from taking a trap
				cpuLvl_q <= {1'b0, regWdata[`IPC_PRIO_W-1:0]};
			end else if (wrHit && regAddr == `IPC_A_EVMASK) begin
				evMask_q <= regWdata[1:0];
			end
			// Flags: new events win over software clears
			flag_q <= ((wrHit && regAddr == `IPC_A_FLAGS) ? regWdata[NSRC-1:0] : flag_q)
				| srcEvent;
			trapFlag_q <= ((wrHit && regAddr == `IPC_A_CTRL1)
				? (trapFlag_q & regWdata[`IPC_NTRAP-1:0]) : trapFlag_q) | trapEvent;
			evSt_q <= (evSt_q & ~((wrHit && regAddr == `IPC_A_EVST) ? regWdata[1:0] : 2'h0))
				| {cpuReturn, cpuAck && irqReq};
			irqOut <= |(evSt_q & evMask_q);
			// Timed disable counter
			if (timedDisStart) begin
				disCnt_q <= timedDisCycles;
			end else if (disCnt_q != {`IPC_DISCNT_W{1'b0}}) begin
				disCnt_q <= disCnt_q - 1'b1;
			end
			// Request presented to the CPU
			irqReq <= pendAny && !(cpuAck && irqReq);
			irqLevel <= pendLvl;
			irqVector <= pendVec;
			if (cpuAck && irqReq) begin
				stackLvl_q[sp_q] <= cpuLvl_q;
				stackSrl_q[sp_q] <= cpuSavedSrl;
				sp_q <= sp_q + 4'h1;
				cpuLvl_q <= irqLevel;
				newLvl_q <= irqLevel;
				vecCode_q <= irqVector;
				inService_q <= 1'b1;
			end else if (cpuReturn && sp_q != 4'h0) begin
				cpuLvl_q <= stackLvl_q[sp_q - 4'h1];
				newLvl_q <= stackLvl_q[sp_q - 4'h1];
				restoredSrl <= stackSrl_q[sp_q - 4'h1];
				restoreValid <= 1'b1;
				sp_q <= sp_q - 4'h1;
				inService_q <= (sp_q != 4'h1);
			end
		end
	end

	// ----------------------------------------
	// Register reads, data one cycle later
	// ----------------------------------------
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= 16'h0000;
		end else if (regRd) begin
			if (regAddr == `IPC_A_PRIO15) begin
				regRdata <= prio15_q;
			end else if (regAddr == `IPC_A_PRIO16) begin
				regRdata <= prio16_q;
			end else if (regAddr == `IPC_A_PRIO17) begin
				regRdata <= prio17_q;
			end else if (regAddr == `IPC_A_STATUS) begin
				regRdata <= {4'h0, newLvl_q, 1'b0, vecCode_q};
			end else if (regAddr == `IPC_A_CTRL1) begin
				regRdata <= {nestDis_q, 11'h000, trapFlag_q};
			end else if (regAddr == `IPC_A_FLAGS) begin
				regRdata <= {8'h00, flag_q};
			end else if (regAddr == `IPC_A_ENABLE) begin
				regRdata <= {8'h00, enable_q};
			end else if (regAddr == `IPC_A_CPULVL) begin
				regRdata <= {12'h000, cpuLvl_q};
			end else if (regAddr == `IPC_A_DISCNT) begin
				regRdata <= {2'h0, disCnt_q};
			end else if (regAddr == `IPC_A_EVST) begin
				regRdata <= {14'h0000, evSt_q};
			end else if (regAddr == `IPC_A_EVMASK) begin
				regRdata <= {14'h0000, evMask_q};
			end else begin
				regRdata <= 16'h0000;
			end
		end else begin
			regRdata <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// ### verification/ipc_prio_props.sv
// Purpose: Port-level assertions for the priority controller
// Assumes: Bound into ipc_prio_ctrl, one clock domain
// Notes:   Read data, request fields and return pulse
`timescale 1ns/100ps
`default_nettype none
`include "ipc_prio_regs.vh"
module ipc_prio_props #(
	parameter NSRC = `IPC_NSRC
) (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Register port
	input wire [`IPC_ADDR_W-1:0] regAddr,
	input wire regRd,
	input wire [15:0] regRdata,
	// Events and CPU link
	input wire [`IPC_NTRAP-1:0] trapEvent,
	input wire cpuAck,
	input wire cpuReturn,
	input wire irqReq,
	input wire [`IPC_LVL_W-1:0] irqLevel,
	input wire [`IPC_VEC_W-1:0] irqVector,
	input wire restoreValid,
	input wire irqOut
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
		else $error("read data not zero outside a read");
	status_bits_a: assert property ($past(regRd) && $past(regAddr) == `IPC_A_STATUS
		|-> regRdata[15:12] == 4'h0 && !regRdata[7]) else $error("status unused bits set");
	prio_bits_a: assert property ($past(regRd) && $past(regAddr) == `IPC_A_PRIO16
		|-> (regRdata & 16'hF88F) == 16'h0000) else $error("priority unused bits set");
	user_level_a: assert property (irqReq && irqVector[6]
		|-> irqLevel != 4'h0 && !irqLevel[3]) else $error("user level out of range");
	trap_level_a: assert property (irqReq && !irqVector[6]
		|-> irqLevel == {2'b10, irqVector[1:0]}) else $error("trap level wrong");
	trap_unmasked_a: assert property (trapEvent[3]
		|-> ##[1:4] irqReq && irqLevel == 4'hB) else $error("top trap not requested");
	ack_drop_a: assert property (irqReq && cpuAck |=> !irqReq)
		else $error("request held after ack");
	restore_cause_a: assert property (restoreValid |-> $past(cpuReturn))
		else $error("restore without return");
	cover property (irqReq && cpuAck);
	cover property (restoreValid);
	cover property (irqReq && !irqVector[6]);
	cover property (irqOut);
endmodule
bind ipc_prio_ctrl ipc_prio_props #(.NSRC(NSRC)) uProps (.clk(clk), .arst_n(arst_n),
	.regAddr(regAddr), .regRd(regRd), .regRdata(regRdata), .trapEvent(trapEvent),
	.cpuAck(cpuAck), .cpuReturn(cpuReturn), .irqReq(irqReq), .irqLevel(irqLevel),
	.irqVector(irqVector), .restoreValid(restoreValid), .irqOut(irqOut));
`default_nettype wire

// ### verification/ipc_cpu_model.sv
// Purpose: CPU side that takes a request and returns after a service time
// Assumes: Takes requests only while ackEn is high
// Notes:   One service level at a time
`timescale 1ns/100ps
`default_nettype none
module ipc_cpu_model #(
	parameter SVC = 8,
	parameter [7:0] STATUS_LOW_BYTE = 8'hA5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Handshake
	input wire logic ackEn,
	input wire logic irqReq,
	output logic cpuAck,
	output logic cpuReturn,
	output logic [7:0] cpuSavedSrl
);
	logic busy_q;
	int cnt_q;
	assign cpuSavedSrl = STATUS_LOW_BYTE;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_q <= 1'b0;
			cnt_q <= 0;
			cpuAck <= 1'b0;
			cpuReturn <= 1'b0;
		end else begin
			cpuAck <= 1'b0;
			cpuReturn <= 1'b0;
			if (busy_q) begin
				cnt_q <= cnt_q - 1;
				if (cnt_q == 0) begin
					cpuReturn <= 1'b1;
					busy_q <= 1'b0;
				end
			end else if (ackEn && irqReq && !cpuAck) begin
				cpuAck <= 1'b1;
				busy_q <= 1'b1;
				cnt_q <= SVC;
			end
		end
	end
endmodule
`default_nettype wire

// ### verification/interrupt_priority_control_test.sv
// Purpose: Self-checking bench for the priority controller
// Assumes: 20 MHz clock, CPU model answers while allowed
// Notes:   Register rows first, then hand-written cases
`timescale 1ns/100ps
`default_nettype none
`include "ipc_prio_regs.vh"
module interrupt_priority_control_test;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] srcEvent = 8'h00;
	logic [3:0] trapEvent = 4'h0;
	logic timedDisStart = 1'b0;
	logic [13:0] timedDisCycles = 14'h0000;
	logic ackEn = 1'b0;
	logic [15:0] regRdata;
	logic cpuAck, cpuReturn, restoreValid, irqReq, irqOut;
	logic [7:0] cpuSavedSrl, restoredSrl;
	logic [3:0] irqLevel;
	logic [6:0] irqVector;
	int failures = 0;
	int compares = 0;
	// Address, write data, expected read back
	logic [35:0] rows [6] = '{36'h0FFFF0077, 36'h1FFFF0770, 36'h2FFFF7777,
		36'h3FFFF0000, 36'hFFFFF0000, 36'h288880000};
	always #25 clk = ~clk;
	ipc_prio_ctrl dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .srcEvent(srcEvent),
		.trapEvent(trapEvent), .cpuAck(cpuAck), .cpuReturn(cpuReturn),
		.cpuSavedSrl(cpuSavedSrl), .timedDisStart(timedDisStart),
		.timedDisCycles(timedDisCycles), .irqReq(irqReq), .irqLevel(irqLevel),
		.irqVector(irqVector), .restoredSrl(restoredSrl), .restoreValid(restoreValid),
		.irqOut(irqOut));
	ipc_cpu_model #(.SVC(8), .STATUS_LOW_BYTE(8'hA5)) cpu (.clk(clk), .arst_n(arst_n), .ackEn(ackEn),
		.irqReq(irqReq), .cpuAck(cpuAck), .cpuReturn(cpuReturn), .cpuSavedSrl(cpuSavedSrl));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		chk(regRdata, exp);
	endtask
	task ev(input logic [7:0] s, input logic [3:0] t);
		@(posedge clk);
		srcEvent <= s;
		trapEvent <= t;
		@(posedge clk);
		srcEvent <= 8'h00;
		trapEvent <= 4'h0;
	endtask
	task waitReq(input logic v);
		int n;
		n = 0;
		while (irqReq !== v && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0000, irqReq}, {15'h0000, v});
	endtask
	task takeReq;
		int n;
		n = 0;
		@(posedge clk);
		ackEn <= 1'b1;
		while (cpuAck !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0000, cpuAck}, 16'h0001);
		@(posedge clk);
		ackEn <= 1'b0;
	endtask
	task print_verdict;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#(4000 * 50);
		failures++;
		print_verdict();
	end
	initial begin
		int n;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i][35:32], rows[i][31:16]);
			rd(rows[i][35:32], rows[i][15:0]);
		end
		$display("register rows done");
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rd(4'h0, 16'h0044);
		rd(4'h1, 16'h0440);
		rd(4'h2, 16'h4444);
		rd(4'h3, 16'h0000);
		$display("reset values done");
		wr(4'h6, 16'h00FF);
		wr(4'h0, 16'h0040);
		wr(4'h2, 16'h4466);
		ev(8'h31, 4'h0);
		waitReq(1'b1);
		chk({12'h000, irqLevel}, 16'h0006);
		chk({9'h000, irqVector}, 16'h0044);
		wr(4'h7, 16'h0007);
		waitReq(1'b0);
		ev(8'h00, 4'h8);
		waitReq(1'b1);
		chk({12'h000, irqLevel}, 16'h000B);
		wr(4'h4, 16'h0000);
		waitReq(1'b0);
		$display("arbitration and masking done");
		wr(4'hA, 16'h0003);
		wr(4'h7, 16'h0000);
		waitReq(1'b1);
		@(posedge clk);
		ackEn <= 1'b1;
		n = 0;
		while (cpuAck !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		ackEn <= 1'b0;
		rd(4'h3, 16'h0644);
		n = 0;
		while (restoreValid !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		chk({8'h00, restoredSrl}, 16'h00A5);
		waitReq(1'b1);
		chk({15'h0000, irqOut}, 16'h0001);
		wr(4'h9, 16'h0003);
		repeat (2) @(negedge clk);
		chk({15'h0000, irqOut}, 16'h0000);
		wr(4'h5, 16'h0000);
		waitReq(1'b0);
		$display("service and return done");
		wr(4'h6, 16'h0000);
		ev(8'h10, 4'h0);
		repeat (4) @(negedge clk);
		chk({15'h0000, irqReq}, 16'h0000);
		wr(4'h6, 16'h00FF);
		waitReq(1'b1);
		wr(4'h5, 16'h0000);
		waitReq(1'b0);
		wr(4'h2, 16'h0076);
		@(posedge clk);
		timedDisStart <= 1'b1;
		timedDisCycles <= 14'd40;
		@(posedge clk);
		timedDisStart <= 1'b0;
		ev(8'h10, 4'h0);
		repeat (4) @(negedge clk);
		chk({15'h0000, irqReq}, 16'h0000);
		ev(8'h20, 4'h0);
		waitReq(1'b1);
		chk({12'h000, irqLevel}, 16'h0007);
		$display("enable and timed disable done");
		wr(4'h5, 16'h0000);
		waitReq(1'b0);
		repeat (40) @(posedge clk);
		wr(4'h4, 16'h8000);
		ev(8'h10, 4'h0);
		waitReq(1'b1);
		takeReq();
		ev(8'h20, 4'h0);
		repeat (3) @(negedge clk);
		chk({15'h0000, irqReq}, 16'h0000);
		n = 0;
		while (restoreValid !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0000, restoreValid}, 16'h0001);
		rd(4'h7, 16'h0000);
		waitReq(1'b1);
		chk({12'h000, irqLevel}, 16'h0007);
		chk({9'h000, irqVector}, 16'h0045);
		wr(4'h4, 16'h0000);
		wr(4'h5, 16'h0000);
		waitReq(1'b0);
		wr(4'h7, 16'h000F);
		ev(8'h00, 4'h1);
		waitReq(1'b1);
		chk({12'h000, irqLevel}, 16'h0008);
		wr(4'h4, 16'h0000);
		waitReq(1'b0);
		wr(4'h7, 16'h0000);
		$display("nesting and trap masking done");
		print_verdict();
	end
endmodule
`default_nettype wire
